// *** shared/orl_consts.vh ***
// Constants of the output relay and indicator block.
// Assumes inclusion by the block's register file and logic.
`ifndef ORL_CONSTS_VH
`define ORL_CONSTS_VH
// ----------------------------------------------------------
// Register byte offsets
// ----------------------------------------------------------
`define ORL_OFF_R5_CTRL 8'h00
`define ORL_OFF_R5_SEL 8'h04
`define ORL_OFF_AL_CTRL 8'h08
`define ORL_OFF_AL_SEL 8'h0C
`define ORL_OFF_AUX_FN 8'h10
`define ORL_OFF_AUX_SEL 8'h14
`define ORL_OFF_TIND 8'h18
`define ORL_OFF_AIND 8'h1C
`define ORL_OFF_PIND 8'h20
`define ORL_OFF_IRQ_STAT 8'h24
`define ORL_OFF_IRQ_MASK 8'h28
`define ORL_OFF_STATE 8'h2C
`define ORL_OFF_IND_CLR 8'h30
// ----------------------------------------------------------
// Combining functions and dropout modes
// ----------------------------------------------------------
`define ORL_FN_DIS 3'h0
`define ORL_FN_OR 3'h1
`define ORL_FN_AND 3'h2
`define ORL_FN_NOR 3'h3
`define ORL_FN_NAND 3'h4
`define ORL_DROP_UNL 2'h0
`define ORL_DROP_LAT 2'h1
`define ORL_DROP_OFF 2'h2
`define ORL_DELAY_MAX 6'h3C
// ----------------------------------------------------------
// Input source codes, zero is unused
// ----------------------------------------------------------
`define ORL_SRC_UNUSED 5'h00
`define ORL_SRC_CLOSE_BKR 5'h01
`define ORL_SRC_TRIP_PROT 5'h02
`define ORL_SRC_TRIP_ALM 5'h03
`define ORL_SRC_SYS_ALM 5'h04
`define ORL_SRC_BKR_ALM 5'h05
// ----------------------------------------------------------
// Reset values
// ----------------------------------------------------------
`define ORL_RST_R5_CTRL 14'h0A21
`define ORL_RST_R5_SEL 32'h0000_0001
`define ORL_RST_AL_CTRL 14'h0001
`define ORL_RST_AL_SEL 32'h0504_0302
`define ORL_RST_AUX_FN 3'h1
`define ORL_RST_AUX_SEL 32'h0000_0000
`define ORL_RST_TIND 15'h0301
`define ORL_RST_AIND 15'h6001
`define ORL_RST_PIND 15'h3F00
`endif

// *** rtl/orl_top.v ***
// Output relay five, alarm relay, auxiliary lamp and the trip,
// alarm and pickup indicators, configured over APB.
// Assumes cycle_tick pulses once per power-system cycle and all
// inputs are synchronous to clk_sys.
//
// Notes on behaviour
// - Each relay and the auxiliary lamp picks OR, AND, NOR, NAND or disabled over four slots.
// - Relays drop out latched, unlatched or after an off-delay.
// - Off-delay of 0 to 60 power-system cycles (cycle_tick pulses) counted after release.
// - Delay count matters only in off-delay dropout mode.
// - Relay five resets to OR, off-delay, 10 cycles, breaker close.
// - Alarm relay resets to OR, unlatched, zero delay, trip protection and three alarms.
// - Auxiliary lamp has a function, default OR, slots unused.
// - Trip indicator latched by default, trip one and two enabled.
// - Alarm indicator latched by default, alarm and healthy enabled.
// - Pickup indicator unlatched, all pickups but protection alarm.
`timescale 1ns/1ps
`include "orl_consts.vh"
module orl_top (
  input wire clk_sys,
  input wire sys_rst,
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [7:0] paddr,
  input wire [31:0] pwdata,
  output wire [31:0] prdata,
  output wire pready,
  output wire pslverr,
  input wire cycle_tick,
  input wire ind_reset_in,
  input wire [31:0] logic_src,
  input wire first_breaker_output,
  input wire second_breaker_output,
  input wire relay_three_output,
  input wire relay_four_output,
  input wire relay_healthy,
  input wire instantaneous_overcurrent_pickup,
  input wire time_overcurrent_pickup,
  input wire voltage_pickup,
  input wire high_frequency_pickup,
  input wire low_frequency_pickup,
  input wire unbalance_pickup,
  input wire prot_alarm_pickup,
  output wire relay_five_output,
  output wire alarm_relay_output,
  output wire auxiliary_lamp_output,
  output wire trip_lamp,
  output wire alarm_lamp,
  output wire pickup_lamp,
  output wire irq
);

  // ----------------------------------------------------------
  // Register bus
  // ----------------------------------------------------------
  reg [13:0] r5_ctrl_r;
  reg [31:0] r5_sel_r;
  reg [13:0] al_ctrl_r;
  reg [31:0] al_sel_r;
  reg [2:0] aux_fn_r;
  reg [31:0] aux_sel_r;
  reg [14:0] tind_r;
  reg [14:0] aind_r;
  reg [14:0] pind_r;
  reg [4:0] irq_stat_r;
  reg [4:0] irq_mask_r;
  reg [31:0] prdata_r;
  reg ind_clr_r;
  wire [2:0] out_r;
  wire [2:0] lamp_r;
  reg [1:0] rly_prev_r;
  reg [2:0] lamp_prev_r;

  wire setup = psel & ~penable;
  wire wr = psel & penable & pwrite;
  reg mapped;
  reg [31:0] rd_nxt;
  wire [5:0] dly_in;
  wire [4:0] irq_evt;
  wire clr_all;

  assign pready = 1'b1;
  assign pslverr = psel & penable & ~mapped;
  assign prdata = prdata_r;
  // Writes above 60 are held at 60
  assign dly_in = (pwdata[13:8] > `ORL_DELAY_MAX) ?
    `ORL_DELAY_MAX : pwdata[13:8];

  always @* begin
    mapped = 1'b1;
    rd_nxt = 32'h0000_0000;
    case (paddr)
      `ORL_OFF_R5_CTRL: rd_nxt = {18'h0_0000, r5_ctrl_r};
      `ORL_OFF_R5_SEL: rd_nxt = r5_sel_r;
      `ORL_OFF_AL_CTRL: rd_nxt = {18'h0_0000, al_ctrl_r};
      `ORL_OFF_AL_SEL: rd_nxt = al_sel_r;
      `ORL_OFF_AUX_FN: rd_nxt = {29'h0000_0000, aux_fn_r};
      `ORL_OFF_AUX_SEL: rd_nxt = aux_sel_r;
      `ORL_OFF_TIND: rd_nxt = {17'h0_0000, tind_r};
      `ORL_OFF_AIND: rd_nxt = {17'h0_0000, aind_r};
      `ORL_OFF_PIND: rd_nxt = {17'h0_0000, pind_r};
      `ORL_OFF_IRQ_STAT: rd_nxt = {27'h000_0000, irq_stat_r};
      `ORL_OFF_IRQ_MASK: rd_nxt = {27'h000_0000, irq_mask_r};
      `ORL_OFF_STATE: rd_nxt = {26'h000_0000, lamp_r, out_r};
      `ORL_OFF_IND_CLR: rd_nxt = 32'h0000_0000;
      default: mapped = 1'b0;
    endcase
  end

  always @(posedge clk_sys) begin
    if (sys_rst) begin
      r5_ctrl_r <= `ORL_RST_R5_CTRL;
      r5_sel_r <= `ORL_RST_R5_SEL;
      al_ctrl_r <= `ORL_RST_AL_CTRL;
      al_sel_r <= `ORL_RST_AL_SEL;
      aux_fn_r <= `ORL_RST_AUX_FN;
      aux_sel_r <= `ORL_RST_AUX_SEL;
      tind_r <= `ORL_RST_TIND;
      aind_r <= `ORL_RST_AIND;
      pind_r <= `ORL_RST_PIND;
      irq_mask_r <= 5'h00;
      prdata_r <= 32'h0000_0000;
      ind_clr_r <= 1'b0;
    end else begin
      ind_clr_r <= 1'b0;
      if (setup) begin
        prdata_r <= rd_nxt;
      end
      if (wr) begin
        case (paddr)
          `ORL_OFF_R5_CTRL:
            r5_ctrl_r <= {dly_in, 2'h0, pwdata[5:4], 1'b0, pwdata[2:0]};
          `ORL_OFF_R5_SEL: r5_sel_r <= pwdata & 32'h1F1F_1F1F;
          `ORL_OFF_AL_CTRL:
            al_ctrl_r <= {dly_in, 2'h0, pwdata[5:4], 1'b0, pwdata[2:0]};
          `ORL_OFF_AL_SEL: al_sel_r <= pwdata & 32'h1F1F_1F1F;
          `ORL_OFF_AUX_FN: aux_fn_r <= pwdata[2:0];
          `ORL_OFF_AUX_SEL: aux_sel_r <= pwdata & 32'h1F1F_1F1F;
          `ORL_OFF_TIND: tind_r <= {pwdata[14:8], 7'h00, pwdata[0]};
          `ORL_OFF_AIND: aind_r <= {pwdata[14:8], 7'h00, pwdata[0]};
          `ORL_OFF_PIND: pind_r <= {pwdata[14:8], 7'h00, pwdata[0]};
          `ORL_OFF_IRQ_MASK: irq_mask_r <= pwdata[4:0];
          `ORL_OFF_IND_CLR: ind_clr_r <= pwdata[0];
          default: ind_clr_r <= 1'b0;
        endcase
      end
    end
  end

  assign clr_all = ind_clr_r | ind_reset_in;

  // ----------------------------------------------------------
  // Combining gates: relay five, alarm relay, auxiliary lamp
  // ----------------------------------------------------------
  wire [8:0] fn_all = {aux_fn_r, al_ctrl_r[2:0], r5_ctrl_r[2:0]};
  wire [95:0] sel_all = {aux_sel_r, al_sel_r, r5_sel_r};
  wire [2:0] gate;

  genvar g;
  generate
    for (g = 0; g < 3; g = g + 1) begin : gen_gate
      wire [31:0] sel = sel_all[32*g+31:32*g];
      wire [2:0] fn = fn_all[3*g+2:3*g];
      wire [3:0] used;
      wire [3:0] val;
      genvar k;
      for (k = 0; k < 4; k = k + 1) begin : gen_slot
        assign used[k] = sel[8*k+4:8*k] != `ORL_SRC_UNUSED;
        assign val[k] = logic_src[sel[8*k+4:8*k]] & used[k];
      end
      // Unused slots take no part; no used slot gives low
      wire any_v = |val;
      wire all_v = (val == used) & (|used);
      reg res;
      always @* begin
        case (fn)
          `ORL_FN_OR: res = any_v;
          `ORL_FN_AND: res = all_v;
          `ORL_FN_NOR: res = ~any_v & (|used);
          `ORL_FN_NAND: res = ~all_v & (|used);
          default: res = 1'b0;
        endcase
      end
      assign gate[g] = res;
    end
  endgenerate

  // ----------------------------------------------------------
  // Relay dropout: latched, unlatched, off-delay
  // ----------------------------------------------------------
  wire [27:0] ctrl_all = {al_ctrl_r, r5_ctrl_r};

  generate
    for (g = 0; g < 2; g = g + 1) begin : gen_rly
      wire [1:0] drop = ctrl_all[14*g+5:14*g+4];
      wire [5:0] dly = ctrl_all[14*g+13:14*g+8];
      reg [5:0] cnt_r;
      reg q_r;
      assign out_r[g] = q_r;
      always @(posedge clk_sys) begin
        if (sys_rst) begin
          q_r <= 1'b0;
          cnt_r <= 6'h00;
        end else if (gate[g]) begin
          q_r <= 1'b1;
          cnt_r <= dly;
        end else begin
          case (drop)
            `ORL_DROP_LAT: begin
              if (clr_all) begin
                q_r <= 1'b0;
              end
            end
            `ORL_DROP_OFF: begin
              // Count only in off-delay mode
              if (cnt_r == 6'h00) begin
                q_r <= 1'b0;
              end else if (cycle_tick) begin
                cnt_r <= cnt_r - 6'h01;
              end
            end
            default: q_r <= 1'b0;
          endcase
        end
      end
    end
  endgenerate

  // Auxiliary lamp follows its gate with no dropout choice
  reg aux_r;
  assign out_r[2] = aux_r;
  always @(posedge clk_sys) begin
    if (sys_rst) begin
      aux_r <= 1'b0;
    end else begin
      aux_r <= gate[2];
    end
  end

  // ----------------------------------------------------------
  // Indicators
  // ----------------------------------------------------------
  wire [6:0] rly_src = {relay_healthy, out_r[1], out_r[0],
    relay_four_output, relay_three_output,
    second_breaker_output, first_breaker_output};
  wire [6:0] pk_src = {prot_alarm_pickup, unbalance_pickup,
    low_frequency_pickup, high_frequency_pickup, voltage_pickup,
    time_overcurrent_pickup, instantaneous_overcurrent_pickup};
  wire [20:0] src_all = {pk_src, rly_src, rly_src};
  wire [44:0] cfg_all = {pind_r, aind_r, tind_r};

  generate
    for (g = 0; g < 3; g = g + 1) begin : gen_ind
      wire [14:0] cfg = cfg_all[15*g+14:15*g];
      // Disabled sources are masked out
      wire hit = |(src_all[7*g+6:7*g] & cfg[14:8]);
      reg q_r;
      assign lamp_r[g] = q_r;
      always @(posedge clk_sys) begin
        if (sys_rst) begin
          q_r <= 1'b0;
        end else if (cfg[0]) begin
          q_r <= hit | (q_r & ~clr_all);
        end else begin
          q_r <= hit;
        end
      end
    end
  endgenerate

  // ----------------------------------------------------------
  // Interrupts: rising edges of relays and indicators
  // ----------------------------------------------------------
  assign irq_evt = {lamp_r & ~lamp_prev_r, out_r[1:0] & ~rly_prev_r};

  always @(posedge clk_sys) begin
    if (sys_rst) begin
      irq_stat_r <= 5'h00;
      rly_prev_r <= 2'h0;
      lamp_prev_r <= 3'h0;
    end else begin
      rly_prev_r <= out_r[1:0];
      lamp_prev_r <= lamp_r;
      // Set wins over a write-one clear
      if (wr && paddr == `ORL_OFF_IRQ_STAT) begin
        irq_stat_r <= (irq_stat_r & ~pwdata[4:0]) | irq_evt;
      end else begin
        irq_stat_r <= irq_stat_r | irq_evt;
      end
    end
  end

  assign irq = |(irq_stat_r & irq_mask_r);
  assign relay_five_output = out_r[0];
  assign alarm_relay_output = out_r[1];
  assign auxiliary_lamp_output = out_r[2];
  assign trip_lamp = lamp_r[0];
  assign alarm_lamp = lamp_r[1];
  assign pickup_lamp = lamp_r[2];

endmodule

// *** bench/orl_top_props.sv ***
// Checker for orl_top, watching its ports only.
// Assumes the bind below; checks hold while config is at defaults.
`timescale 1ns/1ps
module orl_top_props (
  input wire clk_sys,
  input wire sys_rst,
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire ind_reset_in,
  input wire [31:0] logic_src,
  input wire first_breaker_output,
  input wire second_breaker_output,
  input wire relay_healthy,
  input wire instantaneous_overcurrent_pickup,
  input wire relay_five_output,
  input wire alarm_relay_output,
  input wire trip_lamp,
  input wire alarm_lamp,
  input wire pickup_lamp
);
  reg run_r;
  reg dirty_r;
  wire dflt;
  wire wr;
  assign wr = psel & pwrite;
  assign dflt = run_r & ~dirty_r;
  // Config untouched since reset
  always @(posedge clk_sys) begin
    run_r <= ~sys_rst;
    dirty_r <= ~sys_rst & (dirty_r | (wr & penable));
  end
  default clocking @(posedge clk_sys); endclocking
  default disable iff (sys_rst);
  sequence s_r5_fall;
    dflt && relay_five_output ##0 $fell(logic_src[1]);
  endsequence
  a_r5_rise:
    assert property (dflt && logic_src[1] |=> relay_five_output)
    else $error("relay five missed its close slot");
  a_r5_hold:
    assert property (s_r5_fall |=> relay_five_output [*2])
    else $error("relay five dropped before its delay");
  a_alarm_follow:
    assert property (dflt |=> alarm_relay_output == $past(|logic_src[5:2]))
    else $error("alarm relay not OR of its slots");
  a_trip_set:
    assert property (dflt && (first_breaker_output || second_breaker_output)
      |=> trip_lamp)
    else $error("trip lamp missed a trip source");
  a_trip_quiet:
    assert property (dflt && !trip_lamp && !wr && !first_breaker_output &&
      !second_breaker_output |=> !trip_lamp)
    else $error("trip lamp set by a disabled source");
  a_trip_latch:
    assert property (dflt && trip_lamp && !ind_reset_in && !wr |=> trip_lamp)
    else $error("trip lamp dropped without reset");
  a_alarm_lamp:
    assert property (dflt && (relay_healthy || alarm_relay_output)
      |=> alarm_lamp)
    else $error("alarm lamp missed a source");
  a_pickup_set:
    assert property (dflt && instantaneous_overcurrent_pickup |=> pickup_lamp)
    else $error("pickup lamp missed a pickup");
endmodule
bind orl_top orl_top_props u_orl_top_props (.*);

// *** bench/output_relay_indicator_logic_tb.sv ***
// Self-checking bench for orl_top.
// Assumes orl_top and its checker are compiled before it.
`timescale 1ns/1ps
module output_relay_indicator_logic_tb;
  logic clk_sys = 0, sys_rst = 1, psel = 0, penable = 0, pwrite = 0;
  logic cycle_tick = 0, ind_reset_in = 0, relay_healthy = 0, er;
  logic first_breaker_output = 0, second_breaker_output = 0;
  logic relay_three_output = 0, relay_four_output = 0;
  logic instantaneous_overcurrent_pickup = 0, time_overcurrent_pickup = 0;
  logic voltage_pickup = 0, high_frequency_pickup = 0;
  logic low_frequency_pickup = 0, unbalance_pickup = 0;
  logic prot_alarm_pickup = 0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0, logic_src = 32'h0, rd;
  wire [31:0] prdata;
  wire pready, pslverr, relay_five_output, alarm_relay_output, irq;
  wire auxiliary_lamp_output, trip_lamp, alarm_lamp, pickup_lamp;
  wire [6:0] outs = {relay_five_output, alarm_relay_output, irq,
    auxiliary_lamp_output, trip_lamp, alarm_lamp, pickup_lamp};
  integer error_cnt = 0, comparisons = 0, i;
  logic [31:0] rst_tbl [9] = '{32'h0000_0A21, 32'h1, 32'h1,
    32'h0504_0302, 32'h1, 32'h0, 32'h0301, 32'h6001, 32'h3F00};
  // Rows: function, four slot levels, expected output
  logic [7:0] gate_tbl [9] = '{8'h20, 8'h29, 8'h5C, 8'h5F, 8'h61,
    8'h64, 8'h9E, 8'h8F, 8'h1E};
  orl_top u_orl_top (.*);
  always #20 clk_sys = ~clk_sys;
  // ----
  // Tasks
  // ----
  task print_verdict;
    $display("Checks %0d errors %0d", comparisons, error_cnt);
    if (error_cnt == 0 && comparisons > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask
  task chk(input string n, input [31:0] e, input [31:0] g);
    comparisons++;
    if (g !== e) begin
      error_cnt++;
      $display("[ERR] %s exp %h got %h", n, e, g);
    end
  endtask
  task cyc(input integer n);
    repeat (n) @(posedge clk_sys);
    #1;
  endtask
  task apb(input w, input [7:0] a, input [31:0] d);
    integer k;
    k = 0;
    @(posedge clk_sys);
    psel <= 1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk_sys);
    penable <= 1;
    do begin
      @(posedge clk_sys);
      k++;
    end while (pready !== 1'b1 && k < 20);
    if (k >= 20) begin
      error_cnt++;
      print_verdict;
    end
    rd = prdata;
    er = pslverr;
    psel <= 0;
    penable <= 0;
  endtask
  task drv(input [31:0] s, input [4:0] t, input [6:0] p, input c);
    @(posedge clk_sys);
    logic_src <= s;
    {relay_healthy, relay_four_output, relay_three_output,
      second_breaker_output, first_breaker_output} <= t;
    {prot_alarm_pickup, unbalance_pickup, low_frequency_pickup,
      high_frequency_pickup, voltage_pickup, time_overcurrent_pickup,
      instantaneous_overcurrent_pickup} <= p;
    ind_reset_in <= c;
  endtask
  task clr;
    drv(0, 0, 0, 1);
    drv(0, 0, 0, 0);
    cyc(2);
  endtask
  task tick(input integer n);
    repeat (n) begin
      @(posedge clk_sys);
      cycle_tick <= 1;
      @(posedge clk_sys);
      cycle_tick <= 0;
    end
    #1;
  endtask
  task offdly(input integer n);
    drv(32'h2, 0, 0, 0);
    cyc(2);
    chk("r5 on", 1, relay_five_output);
    drv(0, 0, 0, 0);
    tick(n - 1);
    chk("r5 held", 1, relay_five_output);
    tick(1);
    cyc(1);
    chk("r5 off", 0, relay_five_output);
  endtask
  // ----
  // Sequence
  // ----
  initial begin
    cyc(16);
    @(posedge clk_sys);
    sys_rst <= 0;
    for (i = 0; i < 9; i++) begin
      apb(0, 8'(i * 4), 0);
      chk("reset val", rst_tbl[i], rd);
    end
    apb(0, 8'h3C, 0);
    chk("unmapped", 32'h1, {rd[30:0], er});
    chk("aux idle", 0, auxiliary_lamp_output);
    offdly(10);
    drv(32'h8, 0, 0, 0);
    cyc(2);
    chk("alarm relay", 3, {alarm_relay_output, alarm_lamp});
    drv(0, 0, 0, 0);
    cyc(2);
    chk("alarm drop", 1, {alarm_relay_output, alarm_lamp});
    clr;
    for (i = 0; i < 5; i++) begin
      drv(0, 5'(1 << i), 0, 0);
      cyc(2);
      chk("lamps", {i < 2, i == 4}, {trip_lamp, alarm_lamp});
      drv(0, 0, 0, 0);
      cyc(2);
      chk("lamp latch", {i < 2, i == 4}, {trip_lamp, alarm_lamp});
      clr;
      chk("lamp clear", 0, {trip_lamp, alarm_lamp});
    end
    for (i = 0; i < 7; i++) begin
      drv(0, 0, 7'(1 << i), 0);
      cyc(2);
      chk("pickup", i < 6, pickup_lamp);
      drv(0, 0, 0, 0);
      cyc(2);
      chk("pickup drop", 0, pickup_lamp);
    end
    apb(1, 8'h14, 32'h1);
    drv(32'h2, 0, 0, 0);
    cyc(2);
    chk("aux on", 1, auxiliary_lamp_output);
    apb(1, 8'h04, 32'h0403_0201);
    for (i = 0; i < 9; i++) begin
      apb(1, 8'h00, {18'h0, 6'h05, 5'h0, gate_tbl[i][7:5]});
      drv({27'h0, gate_tbl[i][4:1], 1'b0}, 0, 0, 0);
      cyc(2);
      chk("gate", gate_tbl[i][0], relay_five_output);
    end
    apb(1, 8'h00, 32'h3F21);
    apb(0, 8'h00, 0);
    chk("clamp", 32'h3C21, rd);
    offdly(60);
    apb(1, 8'h00, 32'h0311);
    drv(32'h2, 0, 0, 0);
    drv(0, 0, 0, 0);
    tick(5);
    chk("r5 latch", 1, relay_five_output);
    clr;
    chk("r5 clear", 0, relay_five_output);
    chk("irq masked", 0, irq);
    apb(1, 8'h28, 32'h1);
    cyc(1);
    chk("irq on", 1, irq);
    apb(0, 8'h24, 0);
    chk("irq stat", 1, rd[0]);
    apb(1, 8'h24, 32'h1);
    cyc(1);
    chk("irq off", 0, irq);
    drv(32'h2, 0, 0, 0);
    drv(0, 0, 0, 0);
    cyc(2);
    chk("r5 relatch", 1, relay_five_output);
    chk("irq again", 1, irq);
    apb(0, 8'h2C, 0);
    chk("state", 32'h1, rd);
    apb(1, 8'h30, 32'h1);
    cyc(2);
    chk("r5 reg clear", 0, relay_five_output);
    apb(1, 8'h08, 32'h0021);
    drv(32'h4, 0, 0, 0);
    cyc(2);
    chk("al on", 1, alarm_relay_output);
    drv(0, 0, 0, 0);
    cyc(0);
    chk("al hold", 1, alarm_relay_output);
    cyc(1);
    chk("al off", 0, alarm_relay_output);
    // Second reset in mid-run
    @(posedge clk_sys);
    sys_rst <= 1;
    cyc(2);
    chk("reset outs", 0, outs);
    @(posedge clk_sys);
    sys_rst <= 0;
    apb(0, 8'h08, 0);
    chk("al default", 32'h1, rd);
    chk("outs after rst", 0, outs);
    print_verdict;
  end
endmodule
